// ### bfm_pkg.sv
// package for the brake feedback monitor: register map, fields, resets, timing
// assumes a 250 MHz sys_clk and a single ahb-lite slave port
package bfm_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned MIN_REACT_US    = 3000;
    localparam int unsigned MIN_REACT_CYC   = MIN_REACT_US * CLK_MHZ;
    localparam int unsigned OFF_TEST_US     = 500;
    localparam int unsigned OFF_TEST_CYC    = OFF_TEST_US * CLK_MHZ;
    localparam int unsigned ON_TEST_US      = 100;
    localparam int unsigned ON_TEST_CYC     = ON_TEST_US * CLK_MHZ;
    localparam int unsigned TEST_PERIOD_US  = 100000;
    localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_US * CLK_MHZ;
    localparam int unsigned PULSE_HALF_US   = 1000;
    localparam int unsigned PULSE_HALF_CYC  = PULSE_HALF_US * CLK_MHZ;
    localparam int unsigned PULSE_LOW_US    = 1;
    localparam int unsigned PULSE_LOW_CYC   = PULSE_LOW_US * CLK_MHZ;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] VENT_OFS     = 8'h04;
    localparam logic [7:0] APPL_FAST_OFS = 8'h08;
    localparam logic [7:0] APPL_SLOW_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS   = 8'h10;

    // ----------------------------------------
    // control fields and resets
    // ----------------------------------------
    localparam int unsigned CTRL_PULSE_EN  = 0;
    localparam int unsigned CTRL_POL_ONE   = 1;
    localparam int unsigned CTRL_POL_TWO   = 2;
    localparam int unsigned CTRL_AUX_FEED  = 3;
    localparam int unsigned CTRL_FLT_CLR   = 4;
    localparam int unsigned CTRL_INT_FLT   = 5;
    localparam logic [5:0]  CTRL_RST       = 6'h01;
    localparam logic [31:0] VENT_RST       = 32'h0098_9680;
    localparam logic [31:0] APPL_RST       = 32'h0098_9680;

    // ----------------------------------------
    // status fields
    // ----------------------------------------
    localparam int unsigned ST_IO_FLT   = 0;
    localparam int unsigned ST_INT_FLT  = 1;
    localparam int unsigned ST_WIRE_ERR = 2;
    localparam int unsigned ST_FAST_ERR = 3;
    localparam int unsigned ST_FB_ERR   = 4;

    typedef enum logic [2:0]
    {
        BFM_RUN    = 3'b001,
        BFM_IO_FLT = 3'b010,
        BFM_FLT    = 3'b100
    } bfm_state_t;
endpackage

// ### bfm_chan_if.sv
// interface carrying one feedback channel's inputs and results
// assumes the top module drives config and collects the flags
interface bfm_chan_if;
    logic        pwr_on;
    logic        slow_off;
    logic        fb_raw;
    logic        pol;
    logic        run;
    logic [31:0] vent_cyc;
    logic [31:0] appl_fast_cyc;
    logic [31:0] appl_slow_cyc;
    logic        status;
    logic        fb_err;
    logic        fast_err;
    modport mon (input pwr_on, slow_off, fb_raw, pol, run, vent_cyc, appl_fast_cyc, appl_slow_cyc,
                 output status, fb_err, fast_err);
    modport top (output pwr_on, slow_off, fb_raw, pol, run, vent_cyc, appl_fast_cyc, appl_slow_cyc,
                 input status, fb_err, fast_err);
endinterface

// ### bfm_chan.sv
// one feedback channel: window timer, evaluation, load status
// assumes inputs synchronous to sys_clk
module bfm_chan
    import bfm_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic ce,
    bfm_chan_if.mon   ch
);
    logic        pwr_ff;
    logic        open_ff;
    logic [31:0] win_ff;
    logic        fb_prev_ff;
    logic [31:0] stable_ff;
    logic        fb;
    logic        edge_sw;

    assign fb      = ch.fb_raw ^ ch.pol;
    assign edge_sw = ch.pwr_on != pwr_ff;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pwr_ff <= 1'b0;
        else if (ce)
            pwr_ff <= ch.pwr_on;
    end

    // window restarts on every switching edge
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            win_ff  <= 32'h0000_0000;
            open_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (edge_sw)
            begin
                open_ff <= 1'b1;
                win_ff  <= ch.pwr_on ? ch.vent_cyc : (ch.slow_off ? ch.appl_slow_cyc : ch.appl_fast_cyc);
            end
            else if (win_ff != 32'h0000_0000)
                win_ff <= win_ff - 32'h0000_0001;
            else
                open_ff <= 1'b0;
        end
    end

    // reaction time measured between feedback changes
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fb_prev_ff <= 1'b0;
            stable_ff  <= 32'hffff_ffff;
        end
        else if (ce)
        begin
            fb_prev_ff <= fb;
            // first change after a switching edge is the real reaction
            if (edge_sw)
                stable_ff <= 32'hffff_ffff;
            else if (fb != fb_prev_ff)
                stable_ff <= 32'h0000_0000;
            else if (stable_ff != 32'hffff_ffff)
                stable_ff <= stable_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ch.fast_err <= 1'b0;
        else if (ce)
            ch.fast_err <= fb != fb_prev_ff && !edge_sw && open_ff
                           && stable_ff < MIN_REACT_CYC;
    end

    // judge only once the window is over; bounce inside it is left to fast_err
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ch.status <= 1'b0;
            ch.fb_err <= 1'b0;
        end
        else if (ce)
        begin
            ch.status <= !ch.run ? 1'b0 : (!open_ff && !edge_sw) ? pwr_ff : ch.status;
            ch.fb_err <= ch.run && !open_ff && !edge_sw && fb != pwr_ff;
        end
    end
endmodule // bfm_chan

// ### bfm_top.sv
// top of the brake feedback monitor: bus slave, fault state, pulses, output tests
// assumes one sys_clk at 250 MHz, synchronous active-high rst, ahb-lite master
//
// Behaviour
// - feedback faster than 3 ms gives io fault
// - feedback polarity selectable per loop
// - feedback judged only after window expires
// - separate slow/fast application times, one ventilation
// - evaluation continues until output shuts down
// - status changes only after window elapses
// - status one means ventilated, per circuit
// - fault signal high only without faults
// - pulse out a feeds loop one only
// - pulse outputs on in run, io fault
// - no pulsing while any fault present
// - pulsing configurable, enabled by default
// - one enable for both pulse outputs
// - pulsing with aux supply flags wiring error
// - periodic off test, never disableable
// - periodic short positive on test
// - regular output short test
// - any fault drops outputs and status
// - output on only when both inputs high
module bfm_top
    import bfm_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [1:0]  fast_off_pair_one,
    input  wire logic [1:0]  fast_off_pair_two,
    input  wire logic        slow_off_one,
    input  wire logic        slow_off_two,
    input  wire logic        feedback_loop_one,
    input  wire logic        feedback_loop_two,
    input  wire logic        aux_supply_in_use,
    input  wire logic        pos_pole_one_sense,
    input  wire logic        pos_pole_two_sense,
    output logic      [1:0]  power_output_one,
    output logic      [1:0]  power_output_two,
    output logic             test_pulse_out_a,
    output logic             test_pulse_out_b,
    output logic             fault_signal_out,
    output logic             load_status_one,
    output logic             load_status_two
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0]  ctrl_ff;
    logic [31:0] vent_ff;
    logic [31:0] appl_fast_ff;
    logic [31:0] appl_slow_ff;
    logic        wr_ff;
    logic [7:0]  addr_ff;
    logic        wire_err_ff;
    logic        short_err_ff;
    bfm_state_t  state_ff;
    bfm_state_t  nxt_state;
    logic        on_one_ff;
    logic        on_two_ff;
    logic        slow_one_ff;
    logic        slow_two_ff;
    logic [31:0] period_ff;
    logic [31:0] test_ff;
    logic        test_on_ff;
    logic [31:0] pulse_ff;
    logic        pulse_low_ff;
    logic        io_flt;
    logic        run;
    logic        clr;
    logic [4:0]  status_w;

    bfm_chan_if ch_one ();
    bfm_chan_if ch_two ();

    // ----------------------------------------
    // ahb-lite slave, zero wait, always okay
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wr_ff   <= 1'b0;
            addr_ff <= 8'h00;
        end
        else if (ce && hready)
        begin
            wr_ff   <= hsel && htrans[1] && hwrite;
            addr_ff <= haddr[7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_ff      <= CTRL_RST;
            vent_ff      <= VENT_RST;
            appl_fast_ff <= APPL_RST;
            appl_slow_ff <= APPL_RST;
        end
        else if (ce && wr_ff)
        begin
            unique case (addr_ff)
                CTRL_OFS:      ctrl_ff      <= hwdata[5:0];
                VENT_OFS:      vent_ff      <= hwdata;
                APPL_FAST_OFS: appl_fast_ff <= hwdata;
                APPL_SLOW_OFS: appl_slow_ff <= hwdata;
                default:       ctrl_ff      <= ctrl_ff;
            endcase
        end
    end

    assign clr = ce && wr_ff && addr_ff == CTRL_OFS && hwdata[CTRL_FLT_CLR];

    // read data registered from the address phase; unmapped reads zero
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (ce && hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                CTRL_OFS:      hrdata <= {26'h000_0000, ctrl_ff};
                VENT_OFS:      hrdata <= vent_ff;
                APPL_FAST_OFS: hrdata <= appl_fast_ff;
                APPL_SLOW_OFS: hrdata <= appl_slow_ff;
                STATUS_OFS:    hrdata <= {27'h000_0000, status_w};
                default:       hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // power switching and channels
    // ----------------------------------------
    assign run = state_ff == BFM_RUN;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            on_one_ff   <= 1'b0;
            on_two_ff   <= 1'b0;
            slow_one_ff <= 1'b0;
            slow_two_ff <= 1'b0;
        end
        else if (ce)
        begin
            on_one_ff   <= run && &fast_off_pair_one && slow_off_one;
            on_two_ff   <= run && &fast_off_pair_two && slow_off_two;
            slow_one_ff <= &fast_off_pair_one && !slow_off_one;
            slow_two_ff <= &fast_off_pair_two && !slow_off_two;
        end
    end

    assign ch_one.pwr_on        = on_one_ff;
    assign ch_one.slow_off      = slow_one_ff;
    assign ch_one.fb_raw        = feedback_loop_one;
    assign ch_one.pol           = ctrl_ff[CTRL_POL_ONE];
    assign ch_one.run           = run;
    assign ch_one.vent_cyc      = vent_ff;
    assign ch_one.appl_fast_cyc = appl_fast_ff;
    assign ch_one.appl_slow_cyc = appl_slow_ff;
    assign ch_two.pwr_on        = on_two_ff;
    assign ch_two.slow_off      = slow_two_ff;
    assign ch_two.fb_raw        = feedback_loop_two;
    assign ch_two.pol           = ctrl_ff[CTRL_POL_TWO];
    assign ch_two.run           = run;
    assign ch_two.vent_cyc      = vent_ff;
    assign ch_two.appl_fast_cyc = appl_fast_ff;
    assign ch_two.appl_slow_cyc = appl_slow_ff;

    // evaluation, windows and status per loop
    bfm_chan u_ch_one
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .ch      (ch_one)
    );

    bfm_chan u_ch_two
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .ch      (ch_two)
    );

    // ----------------------------------------
    // output tests
    // ----------------------------------------
    // off test always on: no control bit reaches it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            period_ff  <= 32'h0000_0000;
            test_ff    <= 32'h0000_0000;
            test_on_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (period_ff == TEST_PERIOD_CYC - 1)
            begin
                period_ff  <= 32'h0000_0000;
                test_ff    <= 32'h0000_0000;
                test_on_ff <= 1'b1;
            end
            else
            begin
                period_ff <= period_ff + 32'h0000_0001;
                if (test_on_ff)
                begin
                    test_ff    <= test_ff + 32'h0000_0001;
                    test_on_ff <= test_ff < OFF_TEST_CYC - 1;
                end
            end
        end
    end

    // on test shorter than off test so the load never moves;
    // during a test, a positive pole seen high while its own drive is low is a short
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            short_err_ff <= 1'b0;
        else if (ce)
        begin
            if (test_on_ff && ((!power_output_one[1] && pos_pole_one_sense)
                || (!power_output_two[1] && pos_pole_two_sense)))
                short_err_ff <= 1'b1;
            else if (clr)
                short_err_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            power_output_one <= 2'b00;
            power_output_two <= 2'b00;
        end
        else if (ce)
        begin
            power_output_one <= on_one_ff ? {2{!test_on_ff}}
                              : {test_on_ff && test_ff < ON_TEST_CYC && run, 1'b0};
            power_output_two <= on_two_ff ? {2{!test_on_ff}}
                              : {test_on_ff && test_ff < ON_TEST_CYC && run, 1'b0};
        end
    end

    // ----------------------------------------
    // fault state
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wire_err_ff <= 1'b0;
        else if (ce)
        begin
            if (ctrl_ff[CTRL_PULSE_EN] && aux_supply_in_use)
                wire_err_ff <= 1'b1;
            else if (clr)
                wire_err_ff <= 1'b0;
        end
    end

    assign io_flt = ch_one.fast_err || ch_two.fast_err
                 || ch_one.fb_err || ch_two.fb_err
                 || wire_err_ff || short_err_ff;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            BFM_RUN:    if (ctrl_ff[CTRL_INT_FLT]) nxt_state = BFM_FLT;
                        else if (io_flt) nxt_state = BFM_IO_FLT;
            BFM_IO_FLT: if (ctrl_ff[CTRL_INT_FLT]) nxt_state = BFM_FLT;
                        else if (clr && !wire_err_ff && !short_err_ff) nxt_state = BFM_RUN;
            BFM_FLT:    if (clr && !ctrl_ff[CTRL_INT_FLT]) nxt_state = BFM_RUN;
            default:    nxt_state = BFM_FLT;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_ff <= BFM_RUN;
        else if (ce)
            state_ff <= nxt_state;
    end

    assign status_w = {ch_one.fb_err | ch_two.fb_err, ch_one.fast_err | ch_two.fast_err,
                       wire_err_ff | short_err_ff, state_ff == BFM_FLT, state_ff == BFM_IO_FLT};

    // ----------------------------------------
    // test pulses and signal outputs
    // ----------------------------------------
    // one shared enable and one generator, so both loops pulse together
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pulse_ff     <= 32'h0000_0000;
            pulse_low_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (pulse_ff == PULSE_HALF_CYC - 1)
                pulse_ff <= 32'h0000_0000;
            else
                pulse_ff <= pulse_ff + 32'h0000_0001;
            pulse_low_ff <= run && ctrl_ff[CTRL_PULSE_EN] && pulse_ff < PULSE_LOW_CYC;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            test_pulse_out_a <= 1'b0;
            test_pulse_out_b <= 1'b0;
            fault_signal_out <= 1'b0;
            load_status_one  <= 1'b0;
            load_status_two  <= 1'b0;
        end
        else if (ce)
        begin
            test_pulse_out_a <= state_ff != BFM_FLT && !pulse_low_ff;
            test_pulse_out_b <= state_ff != BFM_FLT && !pulse_low_ff;
            fault_signal_out <= run && !io_flt;
            load_status_one  <= ch_one.status;
            load_status_two  <= ch_two.status;
        end
    end
endmodule // bfm_top

// ### bfm_fb_model.sv
// feedback switch partner for one brake channel
// assumes pwr is the {pos,neg} drive of that channel
module bfm_fb_model
#(
    parameter int DLY = 5
)
(
    input  wire logic       sys_clk,
    input  wire logic [1:0] pwr,
    input  wire logic       pol,
    input  wire logic [1:0] mode,
    output logic            fb,
    output logic            pos_sense
);
    timeunit 1ns;
    timeprecision 100ps;
    logic st_ff   = 1'b0;
    logic seen_ff = 1'b0;
    int   cnt_ff  = 0;
    // ----
    // reacts DLY+1 cycles after the pole moves; mode 1 stuck, mode 2 bounces
    // ----
    assign fb        = st_ff ^ pol;
    assign pos_sense = pwr[1];
    always @(posedge sys_clk)
    begin
        seen_ff <= pwr[1];
        cnt_ff  <= (pwr[1] != seen_ff) ? 1 : (cnt_ff > 0 && cnt_ff < DLY + 3) ? cnt_ff + 1 : 0;
        if (cnt_ff == DLY && mode != 2'h1)
            st_ff <= pwr[1];
        if (mode == 2'h2 && cnt_ff == DLY + 1)
            st_ff <= ~st_ff;
        if (mode == 2'h2 && cnt_ff == DLY + 2)
            st_ff <= pwr[1];
    end
endmodule // bfm_fb_model

// ### bfm_top_sva.sv
// port checker for bfm_top
// assumes one clock domain, bound below
module bfm_top_sva
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [1:0] fast_off_pair_one,
    input wire logic [1:0] fast_off_pair_two,
    input wire logic [1:0] power_output_one,
    input wire logic [1:0] power_output_two,
    input wire logic       test_pulse_out_a,
    input wire logic       test_pulse_out_b,
    input wire logic       fault_signal_out,
    input wire logic       load_status_one,
    input wire logic       load_status_two
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // negative pole only, except fault_drop_a: the on test moves the positive pole
    // ----
    off_one_a: assert property (fast_off_pair_one != 2'h3 |-> ##2 !power_output_one[0])
        else $error("pole one on without pair");
    off_two_a: assert property (fast_off_pair_two != 2'h3 |-> ##2 !power_output_two[0])
        else $error("pole two on without pair");
    on_one_a: assert property ($rose(power_output_one[0]) |-> $past(fast_off_pair_one, 2) == 2'h3)
        else $error("output one rose early");
    on_two_a: assert property ($rose(power_output_two[0]) |-> $past(fast_off_pair_two, 2) == 2'h3)
        else $error("output two rose early");
    hold_one_a: assert property ($rose(power_output_one[0]) |-> !load_status_one [*4])
        else $error("status one moved with output");
    hold_two_a: assert property ($rose(power_output_two[0]) |-> !load_status_two [*4])
        else $error("status two moved with output");
    pulse_pair_a: assert property (test_pulse_out_a == test_pulse_out_b)
        else $error("pulse outputs differ");
    fault_drop_a: assert property (!fault_signal_out [*3] |->
        power_output_one == 2'h0 && power_output_two == 2'h0 && !load_status_one && !load_status_two)
        else $error("outputs live in fault");
endmodule // bfm_top_sva

bind bfm_top bfm_top_sva chk_u (.sys_clk, .rst, .fast_off_pair_one, .fast_off_pair_two, .power_output_one,
    .power_output_two, .test_pulse_out_a, .test_pulse_out_b, .fault_signal_out, .load_status_one, .load_status_two);

// ### brake_feedback_monitor_tb.sv
// self-checking bench for bfm_top
// assumes bfm_fb_model on each loop, ahb-lite master tasks here
module brake_feedback_monitor_tb
    import bfm_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, rst, hsel, hwrite, rdy, resp, aux, s1, s2, pl2;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans, p1, p2, m1, po1, po2;
    logic        f1, f2, ps1, ps2, ta, tb, fso, ls1, ls2;
    int          errors, n_compared;
    logic [7:0]  ofs [6] = '{CTRL_OFS, VENT_OFS, APPL_FAST_OFS, APPL_SLOW_OFS, STATUS_OFS, 8'h20};
    logic [31:0] rv [6] = '{32'h0000_0001, VENT_RST, APPL_RST, APPL_RST, 32'h0, 32'h0};
    logic [31:0] wv [6] = '{32'h0000_0005, 32'h0000_0014, 32'h0000_0014, 32'h0000_0028, 32'h0, 32'hffff_ffff};
    always #2 sys_clk = ~sys_clk;
    bfm_top dut_u (.sys_clk, .rst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(rdy), .hrdata, .hreadyout(rdy), .hresp(resp), .fast_off_pair_one(p1), .fast_off_pair_two(p2),
        .slow_off_one(s1), .slow_off_two(s2), .feedback_loop_one(f1), .feedback_loop_two(f2),
        .aux_supply_in_use(aux), .pos_pole_one_sense(ps1), .pos_pole_two_sense(ps2), .power_output_one(po1),
        .power_output_two(po2), .test_pulse_out_a(ta), .test_pulse_out_b(tb), .fault_signal_out(fso),
        .load_status_one(ls1), .load_status_two(ls2));
    bfm_fb_model fb_one_u (.sys_clk, .pwr(po1), .pol(1'b0), .mode(m1), .fb(f1), .pos_sense(ps1));
    bfm_fb_model fb_two_u (.sys_clk, .pwr(po2), .pol(pl2), .mode(2'h0), .fb(f2), .pos_sense(ps2));
    // ----
    // tasks
    // ----
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic rdy_wait();
        int n;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (rdy !== 1'b1 && n < 64);
        if (rdy !== 1'b1)
        begin
            errors++;
            print_verdict();
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        rdy_wait();
        htrans <= 2'h0;
        hwdata <= d;
        rdy_wait();
        r = hrdata;
    endtask
    task automatic cw(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %0t reg %h exp %h", $time, g, e);
        end
    endtask
    // pins {po1, po2, ta, tb, fso, ls1, ls2} under mask
    task automatic cp(input logic [8:0] e, input logic [8:0] m);
        n_compared++;
        if (({po1, po2, ta, tb, fso, ls1, ls2} & m) !== e)
        begin
            errors++;
            $display("ERROR %0t pins %h exp %h", $time, {po1, po2, ta, tb, fso, ls1, ls2}, e);
        end
    endtask
    task automatic pairs(input logic [1:0] v);
        p1 <= v;
        p2 <= v;
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        {sys_clk, hsel, hwrite, aux, pl2} = 5'h00;
        {rst, s1, s2} = 3'h7;
        {haddr, hwdata, htrans, p1, p2, m1} = 72'h0;
        errors = 0;
        n_compared = 0;
        tk(16);
        rst <= 1'b0;
        tk(3);
        cp(9'h004, 9'h1ff);
        tk(260);
        cp(9'h01c, 9'h1ff);
        foreach (ofs[i])
        begin
            xfer(1'b0, ofs[i], 32'h0);
            cw(r, rv[i]);
        end
        // model polarity flips in the step the control word lands
        foreach (ofs[i])
        begin
            xfer(1'b1, ofs[i], wv[i]);
            pl2 <= 1'b1;
        end
        foreach (ofs[i])
        begin
            xfer(1'b0, ofs[i], 32'h0);
            cw(r, (i == 5) ? 32'h0 : wv[i]);
        end
        $display("registers done");
        pairs(2'h3);
        tk(10);
        cp(9'h1fc, 9'h1ff);
        tk(25);
        cp(9'h1ff, 9'h1ff);
        pairs(2'h0);
        tk(10);
        cp(9'h01f, 9'h1ff);
        tk(25);
        cp(9'h01c, 9'h1ff);
        pairs(2'h3);
        tk(35);
        s1 <= 1'b0;
        s2 <= 1'b0;
        tk(30);
        cp(9'h003, 9'h003);
        tk(20);
        cp(9'h000, 9'h003);
        pairs(2'h0);
        tk(2);
        s1 <= 1'b1;
        s2 <= 1'b1;
        tk(30);
        $display("switching done");
        for (int k = 1; k < 3; k++)
        begin
            m1 <= k[1:0];
            pairs(2'h3);
            tk(40);
            cp(9'h018, 9'h1ff);
            xfer(1'b0, STATUS_OFS, 32'h0);
            cw({31'h0, r[ST_IO_FLT]}, 32'h1);
            pairs(2'h0);
            m1 <= 2'h0;
            tk(40);
            xfer(1'b1, CTRL_OFS, 32'h0000_0015);
            tk(4);
            cp(9'h01c, 9'h1ff);
        end
        $display("io fault done");
        xfer(1'b1, CTRL_OFS, 32'h0000_0025);
        tk(4);
        cp(9'h000, 9'h1ff);
        xfer(1'b0, STATUS_OFS, 32'h0);
        cw({31'h0, r[ST_INT_FLT]}, 32'h1);
        // clear is judged against the old control word, so twice
        xfer(1'b1, CTRL_OFS, 32'h0000_0015);
        xfer(1'b1, CTRL_OFS, 32'h0000_0015);
        tk(4);
        cp(9'h01c, 9'h1ff);
        $display("internal fault done");
        xfer(1'b1, CTRL_OFS, 32'h0000_0004);
        aux <= 1'b1;
        tk(4);
        xfer(1'b0, STATUS_OFS, 32'h0);
        cw({31'h0, r[ST_WIRE_ERR]}, 32'h0);
        xfer(1'b1, CTRL_OFS, 32'h0000_0005);
        tk(4);
        xfer(1'b0, STATUS_OFS, 32'h0);
        cw({31'h0, r[ST_WIRE_ERR]}, 32'h1);
        aux <= 1'b0;
        xfer(1'b1, CTRL_OFS, 32'h0000_0015);
        xfer(1'b1, CTRL_OFS, 32'h0000_0015);
        tk(4);
        cp(9'h01c, 9'h1ff);
        $display("wiring done");
        print_verdict();
    end
endmodule // brake_feedback_monitor_tb
